// ### scl_cpu_model.sv
// processor-side check responder for the loader
// assumes it shares the loader clock; verdict comes from the bench
`timescale 1ns/1ps
`default_nettype none
module scl_cpu_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic busy,
	input  wire logic fail,
	output var  logic done,
	output var  logic pass
);
	logic [3:0] cnt_q;
	// verdict a few cycles into the check, well inside the window
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			cnt_q <= 4'h0;
			done <= 1'b0;
			pass <= 1'b0;
		end
		else
		begin
			cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
			done <= busy && cnt_q == 4'h4;
			pass <= busy && cnt_q == 4'h4 && !fail;
		end
endmodule // scl_cpu_model
`default_nettype wire

// ### scl_defs.vh
// constants for the program memory loader: register offsets, control bit positions, reset values, timing
// assumes a 250 MHz core clock and an internal I2C slave front end that decodes commands
`ifndef SCL_DEFS_VH
`define SCL_DEFS_VH

// ----------------------------------------
// register commands
// ----------------------------------------
`define SCL_CMD_CTRL        8'h60
`define SCL_CMD_DATA        8'h61
`define SCL_CMD_START_LO    8'h62
`define SCL_CMD_START_HI    8'h63
`define SCL_CMD_VERSION     8'h41

// ----------------------------------------
// control bit positions
// ----------------------------------------
`define SCL_BIT_ACC_SEL     7
`define SCL_BIT_CPU_HOLD    6
`define SCL_BIT_PAR_CHK     4
`define SCL_BIT_RUN_EN      3
`define SCL_BIT_PARITY_MEMORY_SELECT     2
`define SCL_BIT_RD_SEL      1
`define SCL_BIT_PTR_CLR     0
`define SCL_CTRL_MASK       8'hdf

// ----------------------------------------
// reset values and version codes
// ----------------------------------------
`define SCL_CTRL_RESET      8'h00
`define SCL_START_RESET     8'h00
`define SCL_VER_RESET       8'h00
`define SCL_VER_INVALID     8'hff

// ----------------------------------------
// timing
// ----------------------------------------
`define SCL_CLK_MHZ         250
`define SCL_CHECK_US        1000
`define SCL_CHECK_CYCLES    (`SCL_CHECK_US * `SCL_CLK_MHZ)

`endif

// ### scl_loader.v
// program memory loader: control, start location, data port, parity port, compatibility check
// assumes an I2C slave front end on CLK that presents decoded byte writes, reads and stop events
`timescale 1ns/1ps
`default_nettype none
`include "scl_defs.vh"
module scl_loader #(
	parameter PAW          = 10,
	parameter CHECK_CYCLES = `SCL_CHECK_CYCLES,
	parameter VERSION_CODE = 8'h5a // arbitrary version value for a valid load
) (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire        WR_STB,
	input  wire        RD_STB,
	input  wire [7:0]  CMD,
	input  wire [7:0]  WDATA,
	input  wire        STOP_STB,
	input  wire        CHANNEL_GROUP_ADDRESS_BIT,
	input  wire        BROADCAST_HIT,
	output reg  [7:0]  RDATA,
	output wire        CPU_HOLD,
	output wire        RUN_FROM_MEMORY,
	output wire        PARITY_CHECK_ENABLE,
	output wire        SAFE_MODE,
	output wire        CHECK_BUSY,
	input  wire        CHECK_DONE,
	input  wire        CHECK_PASS,
	input  wire [PAW-1:0] FETCH_ADDR,
	output wire [7:0]  FETCH_DATA,
	output reg         FETCH_PARITY_ERR
);
	// ----------------------------------------
	// access qualification
	// ----------------------------------------
	wire loader_ok = !CHANNEL_GROUP_ADDRESS_BIT || BROADCAST_HIT;
	wire wr        = WR_STB && loader_ok;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [7:0]  ctrl_q;
	reg  [15:0] load_start_location_q;
	reg  [7:0]  version_q;
	reg  [15:0] ptr_q;
	reg         ptr_armed_q;
	reg         safe_q;
	reg  [31:0] chk_cnt_q;

	localparam ST_IDLE  = 3'b001;
	localparam ST_CHECK = 3'b010;
	localparam ST_RUN   = 3'b100;
	reg  [2:0]  st_q;

	wire loader_access_select = ctrl_q[`SCL_BIT_ACC_SEL];
	wire parity_memory_select = ctrl_q[`SCL_BIT_PARITY_MEMORY_SELECT];
	wire read_not_write_select = ctrl_q[`SCL_BIT_RD_SEL];
	wire pointer_clear        = ctrl_q[`SCL_BIT_PTR_CLR];
	wire ctrl_wr   = wr && CMD == `SCL_CMD_CTRL;
	wire run_rise  = ctrl_wr && WDATA[`SCL_BIT_RUN_EN] && !ctrl_q[`SCL_BIT_RUN_EN];
	wire data_wr   = wr && CMD == `SCL_CMD_DATA && loader_access_select && !read_not_write_select
		&& !pointer_clear && ptr_armed_q;
	wire data_rd   = RD_STB && loader_ok && CMD == `SCL_CMD_DATA && loader_access_select
		&& read_not_write_select && !pointer_clear && ptr_armed_q;
	wire check_end = st_q == ST_CHECK && (CHECK_DONE || chk_cnt_q >= CHECK_CYCLES - 1);

	// ----------------------------------------
	// control and start location
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_q                <= `SCL_CTRL_RESET;
			load_start_location_q <= {2{`SCL_START_RESET}};
		end
		else
		begin
			if (ctrl_wr)
				ctrl_q <= WDATA & `SCL_CTRL_MASK;
			else if (check_end && !(CHECK_DONE && CHECK_PASS))
				ctrl_q[`SCL_BIT_RUN_EN] <= 1'b0;
			if (wr && CMD == `SCL_CMD_START_LO)
				load_start_location_q[7:0] <= WDATA;
			if (wr && CMD == `SCL_CMD_START_HI)
				load_start_location_q[15:8] <= WDATA;
		end
	end

	// ----------------------------------------
	// address pointer
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ptr_q       <= 16'h0000;
			ptr_armed_q <= 1'b0;
		end
		else if (pointer_clear)
		begin
			ptr_q       <= load_start_location_q;
			ptr_armed_q <= 1'b1;
		end
		else
		begin
			if (data_wr || data_rd)
				ptr_q <= ptr_q + 16'h0001;
			// stream ends at stop; pointer kept, next pointer clear re-arms
			if (STOP_STB)
				ptr_armed_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// program and parity memories
	// ----------------------------------------
	wire          mem_access = loader_access_select;
	wire [PAW-1:0] maddr     = mem_access ? ptr_q[PAW-1:0] : FETCH_ADDR;
	wire [7:0]    prog_rd;
	wire [7:0]    par_rd;

	scl_mem #(.AW(PAW)) u_prog (
		.clk   (CLK),
		.we    (data_wr && !parity_memory_select),
		.addr  (maddr),
		.wdata (WDATA),
		.rdata (prog_rd)
	);

	scl_mem #(.AW(PAW)) u_par (
		.clk   (CLK),
		.we    (data_wr && parity_memory_select),
		.addr  (maddr),
		.wdata (WDATA),
		.rdata (par_rd)
	);

	assign FETCH_DATA = prog_rd;

	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			FETCH_PARITY_ERR <= 1'b0;
		else
			FETCH_PARITY_ERR <= ctrl_q[`SCL_BIT_PAR_CHK] && ctrl_q[`SCL_BIT_RUN_EN] && !mem_access
				&& ((^prog_rd) != par_rd[0]);
	end

	// ----------------------------------------
	// compatibility check
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st_q      <= ST_IDLE;
			chk_cnt_q <= 32'h0000_0000;
			version_q <= `SCL_VER_RESET;
			safe_q    <= 1'b0;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					chk_cnt_q <= 32'h0000_0000;
					if (run_rise)
						st_q <= ST_CHECK;
				end
				ST_CHECK:
				begin
					chk_cnt_q <= chk_cnt_q + 32'h0000_0001;
					if (check_end)
					begin
						if (CHECK_DONE && CHECK_PASS)
						begin
							version_q <= VERSION_CODE[7:0];
							safe_q    <= 1'b0;
							st_q      <= ST_RUN;
						end
						else
						begin
							version_q <= `SCL_VER_INVALID;
							safe_q    <= 1'b1;
							st_q      <= ST_IDLE;
						end
					end
				end
				ST_RUN:
				begin
					if (ctrl_wr && !WDATA[`SCL_BIT_RUN_EN])
						st_q <= ST_IDLE;
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			RDATA <= 8'h00;
		else if (RD_STB)
		begin
			case (CMD)
				`SCL_CMD_CTRL:     RDATA <= ctrl_q;
				`SCL_CMD_START_LO: RDATA <= load_start_location_q[7:0];
				`SCL_CMD_START_HI: RDATA <= load_start_location_q[15:8];
				`SCL_CMD_VERSION:  RDATA <= version_q;
				`SCL_CMD_DATA:     RDATA <= parity_memory_select ? par_rd : prog_rd;
				default:           RDATA <= 8'h00;
			endcase
		end
	end

	assign CPU_HOLD            = ctrl_q[`SCL_BIT_CPU_HOLD];
	assign RUN_FROM_MEMORY     = ctrl_q[`SCL_BIT_RUN_EN] && st_q != ST_CHECK;
	assign PARITY_CHECK_ENABLE = ctrl_q[`SCL_BIT_PAR_CHK];
	assign SAFE_MODE           = safe_q;
	assign CHECK_BUSY          = st_q == ST_CHECK;
endmodule // scl_loader
`default_nettype wire

// ### scl_loader_chk.sv
// assertions on the loader control and check flow
// assumes binding onto scl_loader, one clock domain
`timescale 1ns/1ps
`default_nettype none
module scl_loader_chk #(
	parameter CHECK_CYCLES = 250000
) (
	input wire logic       CLK,
	input wire logic       RST_N,
	input wire logic       WR_STB,
	input wire logic [7:0] CMD,
	input wire logic [7:0] WDATA,
	input wire logic       CHANNEL_GROUP_ADDRESS_BIT,
	input wire logic       BROADCAST_HIT,
	input wire logic       CPU_HOLD,
	input wire logic       RUN_FROM_MEMORY,
	input wire logic       PARITY_CHECK_ENABLE,
	input wire logic       SAFE_MODE,
	input wire logic       CHECK_BUSY,
	input wire logic       CHECK_DONE,
	input wire logic       CHECK_PASS
);
	int unsigned busy_cnt_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// cycles spent in the current check
	always @(posedge CLK or negedge RST_N)
		if (!RST_N)
			busy_cnt_q <= 0;
		else
			busy_cnt_q <= CHECK_BUSY ? busy_cnt_q + 1 : 0;
	sequence ctrl_wr;
		WR_STB && CMD == 8'h60 && (!CHANNEL_GROUP_ADDRESS_BIT || BROADCAST_HIT);
	endsequence
	sequence run_wr;
		ctrl_wr ##0 (WDATA == 8'h18 && !RUN_FROM_MEMORY && !CHECK_BUSY);
	endsequence
	ctrl_take_a: assert property (ctrl_wr |=> CPU_HOLD == $past(WDATA[6]) &&
		PARITY_CHECK_ENABLE == $past(WDATA[4])) else $error("control write not taken");
	upper_ignore_a: assert property (WR_STB && CMD == 8'h60 && CHANNEL_GROUP_ADDRESS_BIT &&
		!BROADCAST_HIT |=> $stable(CPU_HOLD)) else $error("upper address write took effect");
	run_start_a: assert property (run_wr |=> CHECK_BUSY [*2]) else $error("check did not start");
	check_bound_a: assert property (busy_cnt_q <= CHECK_CYCLES) else $error("check overran");
	busy_norun_a: assert property (CHECK_BUSY |-> !RUN_FROM_MEMORY) else $error("run during check");
	fail_safe_a: assert property (CHECK_BUSY && CHECK_DONE && !CHECK_PASS |=>
		SAFE_MODE && !RUN_FROM_MEMORY) else $error("failed load not safe");
	pass_run_a: assert property (CHECK_BUSY && CHECK_DONE && CHECK_PASS |=>
		RUN_FROM_MEMORY && !SAFE_MODE) else $error("valid load not running");
	safe_keep_a: assert property ($fell(SAFE_MODE) |-> $past(CHECK_DONE && CHECK_PASS))
		else $error("safe mode left early");
endmodule // scl_loader_chk
bind scl_loader scl_loader_chk #(.CHECK_CYCLES(CHECK_CYCLES)) u_chk (
	.CLK                       (CLK),
	.RST_N                     (RST_N),
	.WR_STB                    (WR_STB),
	.CMD                       (CMD),
	.WDATA                     (WDATA),
	.CHANNEL_GROUP_ADDRESS_BIT (CHANNEL_GROUP_ADDRESS_BIT),
	.BROADCAST_HIT             (BROADCAST_HIT),
	.CPU_HOLD                  (CPU_HOLD),
	.RUN_FROM_MEMORY           (RUN_FROM_MEMORY),
	.PARITY_CHECK_ENABLE       (PARITY_CHECK_ENABLE),
	.SAFE_MODE                 (SAFE_MODE),
	.CHECK_BUSY                (CHECK_BUSY),
	.CHECK_DONE                (CHECK_DONE),
	.CHECK_PASS                (CHECK_PASS)
);
`default_nettype wire

// ### scl_mem.v
// single port byte memory with registered read data
// assumes one clock domain; write and read share one address
`timescale 1ns/1ps
`default_nettype none
module scl_mem #(
	parameter AW = 10
) (
	input  wire          clk,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [7:0]    wdata,
	output reg  [7:0]    rdata
);
	reg [7:0] mem [0:(1<<AW)-1];

	always @(posedge clk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end
endmodule // scl_mem
`default_nettype wire

// ### tb_scl_loader.sv
// bench for the program memory loader
// assumes scl_loader, scl_cpu_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_scl_loader;
	logic       clk = 0, rst_n = 0, wr = 0, rd = 0, stop = 0, ab = 0, bc = 0, fail = 0;
	logic [7:0] cmd = 0, wd = 0;
	logic [9:0] fa = 0;
	wire  [7:0] rdata, fdata;
	wire        hold, run, pen, safe, busy, done, pass, perr;
	int         failures = 0, tests_run = 0;
	logic [7:0] img [4] = '{8'h3c, 8'ha5, 8'h0e, 8'h81};
	logic [7:0] rv [4] = '{8'h60, 8'h62, 8'h63, 8'h41};
	localparam int POWERUP_WAIT = 50; // settle time before loading, scaled down
	always #2 clk = ~clk;
	scl_loader #(.CHECK_CYCLES(20)) u_dut (.CLK(clk), .RST_N(rst_n), .WR_STB(wr), .RD_STB(rd), .CMD(cmd),
		.WDATA(wd), .STOP_STB(stop), .CHANNEL_GROUP_ADDRESS_BIT(ab), .BROADCAST_HIT(bc), .RDATA(rdata),
		.CPU_HOLD(hold), .RUN_FROM_MEMORY(run), .PARITY_CHECK_ENABLE(pen), .SAFE_MODE(safe),
		.CHECK_BUSY(busy), .CHECK_DONE(done), .CHECK_PASS(pass), .FETCH_ADDR(fa), .FETCH_DATA(fdata),
		.FETCH_PARITY_ERR(perr));
	scl_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .busy(busy), .fail(fail), .done(done), .pass(pass));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_b(input logic [7:0] c, input logic [7:0] d);
		@(negedge clk);
		cmd = c;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rd_b(input logic [7:0] c, input logic [7:0] exp);
		@(negedge clk);
		cmd = c;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk(rdata, exp);
	endtask
	task automatic setup(input logic [7:0] c);
		wr_b(8'h60, c | 8'h01);
		wr_b(8'h60, c);
	endtask
	task automatic stop_b;
		@(negedge clk);
		stop = 1;
		@(negedge clk);
		stop = 0;
	endtask
	task automatic idle;
		repeat (2) @(negedge clk);
		for (int i = 0; i < 60 && busy !== 1'b0; i++)
			@(negedge clk);
	endtask
	task automatic conclude;
		$display("checks=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#20000;
		failures++;
		conclude();
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rst_n = 1;
		foreach (rv[i])
			rd_b(rv[i], 8'h00);
		wr_b(8'h63, 8'ha5);
		rd_b(8'h63, 8'ha5);
		wr_b(8'h63, 8'h00);
		wr_b(8'h62, 8'h02);
		rd_b(8'h62, 8'h02);
		repeat (POWERUP_WAIT) @(negedge clk);
		setup(8'hc0);
		foreach (img[i])
			wr_b(8'h61, img[i]);
		stop_b();
		chk({7'h0, hold}, 8'h01);
		setup(8'hc2);
		rd_b(8'h61, img[0]);
		stop_b();
		rd_b(8'h61, img[1]);
		rd_b(8'h61, img[1]);
		setup(8'hc2);
		foreach (img[i])
			rd_b(8'h61, img[i]);
		setup(8'hc4);
		foreach (img[i])
			wr_b(8'h61, {7'h0, ^img[i] ^ (i == 3)});
		setup(8'hc6);
		foreach (img[i])
			rd_b(8'h61, {7'h0, ^img[i] ^ (i == 3)});
		ab = 1;
		wr_b(8'h60, 8'h00);
		chk({7'h0, hold}, 8'h01);
		bc = 1;
		fail = 1;
		wr_b(8'h60, 8'h18);
		idle();
		chk({7'h0, safe}, 8'h01);
		rd_b(8'h41, 8'hff);
		rd_b(8'h60, 8'h10);
		{ab, bc, fail} = 3'b000;
		setup(8'hc0);
		foreach (img[i])
			wr_b(8'h61, img[i]);
		wr_b(8'h60, 8'h18);
		idle();
		chk({5'h0, safe, run, pen}, 8'h03);
		rd_b(8'h41, 8'h5a);
		fa = 10'h002;
		repeat (3) @(negedge clk);
		chk(fdata, img[0]);
		chk({7'h0, perr}, 8'h00);
		fa = 10'h005;
		repeat (3) @(negedge clk);
		chk(fdata, img[3]);
		chk({7'h0, perr}, 8'h01);
		wr_b(8'h60, 8'h08);
		repeat (2) @(negedge clk);
		chk({6'h0, run, perr}, 8'h02);
		conclude();
	end
endmodule // tb_scl_loader
`default_nettype wire
